// [memmap_pkg.sv]
// Contract
// - Decode 64 kB program space, variant-sized Flash.
// - Full variant: above 0xFBFF is reserved.
// - Program writes only when store-enable bit set.
// - 256 bytes internal RAM at 0x00-0xFF.
// - Lower 128 bytes reachable directly and indirectly.
// - 0x00-0x1F form four banks of eight.
// - 0x20-0x2F byte and bit addressable.
package memmap_pkg;

    // Flash size variants, in kilobytes.
    localparam int FLASH_KB_64 = 64;
    localparam int FLASH_KB_32 = 32;
    localparam int FLASH_KB_16 = 16;

    // Program address space boundaries.
    localparam logic [15:0] PROG_LAST_USABLE_64K = 16'hFBFF;
    localparam logic [16:0] FLASH_END_64K        = 17'h10000;
    localparam logic [16:0] FLASH_END_32K        = 17'h08000;
    localparam logic [16:0] FLASH_END_16K        = 17'h04000;

    // Position of the store-enable bit in the program store control byte.
    localparam int STORE_EN_BIT = 0;

    // Internal RAM layout.
    localparam int          RAM_DEPTH      = 256;
    localparam int          RAM_AW         = 8;
    localparam logic [7:0]  RAM_LOWER_LAST = 8'h7F;
    localparam logic [7:0]  BANK_LAST      = 8'h1F;
    localparam logic [7:0]  BIT_AREA_FIRST = 8'h20;
    localparam logic [7:0]  BIT_AREA_LAST  = 8'h2F;
    localparam logic [7:0]  BIT_ADDR_LAST  = 8'h7F;

    // Bank select field position inside the core status word.
    localparam int BANK_SEL_LSB = 3;

    // Flash size selection.
    typedef enum logic [1:0] {
        FLASH_64K,
        FLASH_32K,
        FLASH_16K
    } flash_size_e;

    // Data memory addressing forms.
    typedef enum logic [1:0] {
        MODE_DIRECT,
        MODE_INDIRECT,
        MODE_REGISTER,
        MODE_BIT
    } data_mode_e;

    // Program memory request from the core.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } prog_req_s;

    // Program memory answer to the core.
    typedef struct packed {
        logic       flash_hit;
        logic       reserved;
        logic       unbacked;
        logic       store_wr;
        logic [15:0] store_addr;
        logic [7:0]  store_data;
    } prog_ans_s;

    // Data memory request from the core.
    typedef struct packed {
        logic        rd;
        logic        wr;
        data_mode_e  mode;
        logic [7:0]  addr;
        logic [7:0]  wdata;
        logic        bit_wdata;
    } data_req_s;

endpackage

// [ram_256x8.sv]
`timescale 1ns/1ps
// Byte-wide internal RAM with registered read data.
module ram_256x8
    import memmap_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              we,
    input  wire logic [RAM_AW-1:0] waddr,
    input  wire logic [7:0]        wdata,
    input  wire logic [RAM_AW-1:0] raddr,
    output logic      [7:0]        rdata
);

    // Storage array; no reset so it maps onto a plain memory.
    logic [7:0] mem [RAM_DEPTH];

    // Write port.
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read port; data appear one cycle after the address.
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end

endmodule

// [core_memory_map_decode.sv]
`timescale 1ns/1ps
// Program space decode, program store write path and internal RAM.
module core_memory_map_decode
    import memmap_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    input  wire flash_size_e FLASH_SIZE,
    input  wire logic [7:0]  PROGRAM_STORE_CONTROL,
    input  wire logic        EXTERNAL_DATA_MOVE_INSTRUCTION,
    input  wire prog_req_s   PROG_REQ,
    output prog_ans_s        PROG_ANS,
    input  wire logic [7:0]  STATUS_WORD,
    input  wire data_req_s   DATA_REQ,
    output logic [7:0]       DATA_RDATA,
    output logic             DATA_RBIT,
    output logic             DATA_VALID,
    output logic             DATA_ERR
);

    logic [16:0] flash_end;     // One past the last Flash byte.
    logic        in_flash;      // Address falls in backed Flash.
    logic        in_reserved;   // Address falls in the reserved top region.
    logic        store_en;      // Program store write enable bit.
    logic        store_wr;      // Qualified program store write.
    prog_ans_s   prog_ans_reg;  // Registered program answer.

    logic [7:0]  phys_addr;     // Resolved RAM byte address.
    logic [2:0]  bit_pos;       // Bit position for bit access.
    logic        addr_ok;       // Mode may reach the address.
    logic        is_bit;        // Request is a bit access.
    logic        ram_we;        // RAM write strobe.
    logic [7:0]  ram_wdata;     // RAM write byte.
    logic [7:0]  ram_rdata;     // RAM registered read byte.
    logic        rd_pend_reg;   // Read issued last cycle.
    logic        bit_pend_reg;  // Pending read was a bit access.
    logic [2:0]  bit_pos_reg;   // Bit position of pending read.
    logic        err_reg;       // Refused access flag.
    logic [1:0]  bank_sel;      // Active register bank.

    // Size of the backed Flash depends on the variant strap.
    // variant Flash size
    always_comb begin
        case (FLASH_SIZE)
            FLASH_64K: flash_end = FLASH_END_64K;
            FLASH_32K: flash_end = FLASH_END_32K;
            FLASH_16K: flash_end = FLASH_END_16K;
            default:   flash_end = FLASH_END_16K;
        endcase
    end

    // Classify the program address. The top region is only reserved on the
    // full variant; smaller variants simply have no Flash there.
    // reserved top region
    always_comb begin
        in_reserved = (FLASH_SIZE == FLASH_64K) && (PROG_REQ.addr > PROG_LAST_USABLE_64K);
        in_flash    = ({1'b0, PROG_REQ.addr} < flash_end) && !in_reserved;
    end

    // Writes reach program memory only through the external data move with
    // the store bit set; any other write is dropped, keeping code read-only.
    // store write gating
    always_comb begin
        store_en = PROGRAM_STORE_CONTROL[STORE_EN_BIT];
        store_wr = PROG_REQ.wr && EXTERNAL_DATA_MOVE_INSTRUCTION && store_en && in_flash;
    end

    // Program answer is registered so the Flash controller sees clean strobes.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            prog_ans_reg <= '0;
        end else begin
            prog_ans_reg.flash_hit  <= (PROG_REQ.rd || PROG_REQ.wr) && in_flash;
            prog_ans_reg.reserved   <= (PROG_REQ.rd || PROG_REQ.wr) && in_reserved;
            prog_ans_reg.unbacked   <= (PROG_REQ.rd || PROG_REQ.wr) && !in_flash && !in_reserved;
            prog_ans_reg.store_wr   <= store_wr;
            prog_ans_reg.store_addr <= PROG_REQ.addr;
            prog_ans_reg.store_data <= PROG_REQ.wdata;
        end
    end

    assign PROG_ANS = prog_ans_reg;

    // Bank select comes from the status word two-bit field.
    // bank from status
    assign bank_sel = STATUS_WORD[BANK_SEL_LSB +: 2];

    // Resolve each addressing form to a RAM byte. Direct access above the
    // lower half is the special register space, which is not this block.
    always_comb begin
        phys_addr = DATA_REQ.addr;
        bit_pos   = 3'h0;
        addr_ok   = 1'b1;
        is_bit    = 1'b0;
        case (DATA_REQ.mode)
            MODE_DIRECT: begin
                addr_ok = (DATA_REQ.addr <= RAM_LOWER_LAST);
            end
            MODE_INDIRECT: begin
                addr_ok = 1'b1;
            end
            MODE_REGISTER: begin
                phys_addr = {3'h0, bank_sel, DATA_REQ.addr[2:0]};
                addr_ok   = (phys_addr <= BANK_LAST);
            end
            MODE_BIT: begin
                is_bit    = 1'b1;
                phys_addr = 8'(BIT_AREA_FIRST + {4'h0, DATA_REQ.addr[6:3]});
                bit_pos   = DATA_REQ.addr[2:0];
                addr_ok   = (DATA_REQ.addr <= BIT_ADDR_LAST) && (phys_addr <= BIT_AREA_LAST);
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // Bit writes are read-modify-write; the core presents the current byte
    // in wdata, which avoids a second RAM port at the cost of one more cycle.
    // bit write merge
    always_comb begin
        ram_wdata = DATA_REQ.wdata;
        if (is_bit) begin
            ram_wdata[bit_pos] = DATA_REQ.bit_wdata;
        end
        ram_we = DATA_REQ.wr && addr_ok;
    end

    // The 256-byte internal RAM.
    // internal RAM
    ram_256x8 ram_256x8_i (
        .clk   (CORE_CLK),
        .we    (ram_we),
        .waddr (phys_addr),
        .wdata (ram_wdata),
        .raddr (phys_addr),
        .rdata (ram_rdata)
    );

    // Track reads so data return one cycle later with their bit position.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_pend_reg  <= 1'b0;
            bit_pend_reg <= 1'b0;
            bit_pos_reg  <= 3'h0;
        end else begin
            rd_pend_reg  <= DATA_REQ.rd && addr_ok;
            bit_pend_reg <= is_bit;
            bit_pos_reg  <= bit_pos;
        end
    end

    // Refused accesses raise an error flag for one cycle.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= (DATA_REQ.rd || DATA_REQ.wr) && !addr_ok;
        end
    end

    // Byte data come from the RAM output register, forced to zero when no read is pending.
    assign DATA_RDATA = rd_pend_reg ? ram_rdata : 8'h00;
    assign DATA_RBIT  = rd_pend_reg && bit_pend_reg && ram_rdata[bit_pos_reg];
    assign DATA_VALID = rd_pend_reg;
    assign DATA_ERR   = err_reg;

endmodule

// [memmap_properties.sv]
`timescale 1ns/1ps
// Ties each decode answer to the request taken one edge earlier.
module memmap_properties
    import memmap_pkg::*;
(
    input wire logic        CORE_CLK,
    input wire logic        RESETN,
    input wire flash_size_e FLASH_SIZE,
    input wire logic [7:0]  PROGRAM_STORE_CONTROL,
    input wire logic        EXTERNAL_DATA_MOVE_INSTRUCTION,
    input wire prog_req_s   PROG_REQ,
    input wire prog_ans_s   PROG_ANS,
    input wire data_req_s   DATA_REQ,
    input wire logic        DATA_VALID,
    input wire logic        DATA_ERR
);
    // One clock domain, so one default clocking and reset.
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    store_gate_a: assert property (PROG_ANS.store_wr |-> $past(PROG_REQ.wr &&
        EXTERNAL_DATA_MOVE_INSTRUCTION && PROGRAM_STORE_CONTROL[0])) else $error("store write without enable");
    store_grant_a: assert property (PROG_REQ.wr && EXTERNAL_DATA_MOVE_INSTRUCTION &&
        PROGRAM_STORE_CONTROL[0] && FLASH_SIZE == FLASH_64K && PROG_REQ.addr <= 16'hFBFF
        |=> PROG_ANS.store_wr && PROG_ANS.store_addr == $past(PROG_REQ.addr)) else $error("store write lost");
    reserved_top_a: assert property ((PROG_REQ.rd || PROG_REQ.wr) && FLASH_SIZE == FLASH_64K
        && PROG_REQ.addr > 16'hFBFF |=> PROG_ANS.reserved && !PROG_ANS.flash_hit) else $error("top not reserved");
    unbacked_high_a: assert property ((PROG_REQ.rd || PROG_REQ.wr) && FLASH_SIZE != FLASH_64K
        && PROG_REQ.addr[15] |=> PROG_ANS.unbacked && !PROG_ANS.flash_hit) else $error("high not unbacked");
    low_hit_a: assert property ((PROG_REQ.rd || PROG_REQ.wr) && PROG_REQ.addr < 16'h4000
        |=> PROG_ANS.flash_hit) else $error("low flash missed");
    direct_refuse_a: assert property ((DATA_REQ.rd || DATA_REQ.wr) && DATA_REQ.mode == MODE_DIRECT
        && DATA_REQ.addr[7] |=> DATA_ERR && !DATA_VALID) else $error("upper direct accepted");
    indirect_read_a: assert property (DATA_REQ.rd && DATA_REQ.mode == MODE_INDIRECT
        |=> DATA_VALID && !DATA_ERR) else $error("indirect read not answered");
    idle_quiet_a: assert property (!(DATA_REQ.rd || DATA_REQ.wr) |=> !DATA_VALID && !DATA_ERR)
        else $error("answer without request");
    bank_form_a: assert property ((DATA_REQ.rd || DATA_REQ.wr) && DATA_REQ.mode == MODE_REGISTER
        |=> !DATA_ERR) else $error("register form refused");
    bit_range_a: assert property ((DATA_REQ.rd || DATA_REQ.wr) && DATA_REQ.mode == MODE_BIT
        && !DATA_REQ.addr[7] |=> !DATA_ERR) else $error("bit address refused");
endmodule
bind core_memory_map_decode memmap_properties memmap_properties_i (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
    .FLASH_SIZE(FLASH_SIZE), .PROGRAM_STORE_CONTROL(PROGRAM_STORE_CONTROL), .PROG_REQ(PROG_REQ),
    .EXTERNAL_DATA_MOVE_INSTRUCTION(EXTERNAL_DATA_MOVE_INSTRUCTION), .PROG_ANS(PROG_ANS),
    .DATA_REQ(DATA_REQ), .DATA_VALID(DATA_VALID), .DATA_ERR(DATA_ERR));

// [core_model.sv]
`timescale 1ns/1ps
// Core status word: only the bank field is meaningful, the rest churns.
module core_model (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [1:0] bank,
    output logic     [7:0] status_word
);
    logic [7:0] noise_reg; // Toggles so stray decode of other bits shows.
    // Unrelated flags change every cycle; reset gives them a known start.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            noise_reg <= 8'hA5;
        end else begin
            noise_reg <= ~noise_reg;
        end
    end
    assign status_word = {noise_reg[7:5], bank, noise_reg[2:0]};
endmodule

// [core_memory_map_decode_bench.sv]
`timescale 1ns/1ps
// Drives random and corner requests and compares against a byte model.
module core_memory_map_decode_bench
    import memmap_pkg::*;
;
    logic clk, rstn, edm, rbit, valid, err;
    logic [7:0] psc, sw, rdata, mem [256]; // mem mirrors the RAM.
    logic [1:0] bank;
    flash_size_e fsz;
    prog_req_s preq;
    prog_ans_s pans;
    data_req_s dreq;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [7:0] a, y;
    always #5 clk = ~clk;
    core_model core_model_i (.clk(clk), .rstn(rstn), .bank(bank), .status_word(sw));
    core_memory_map_decode core_memory_map_decode_i (.CORE_CLK(clk), .RESETN(rstn), .FLASH_SIZE(fsz),
        .PROGRAM_STORE_CONTROL(psc), .EXTERNAL_DATA_MOVE_INSTRUCTION(edm), .PROG_REQ(preq), .PROG_ANS(pans),
        .STATUS_WORD(sw), .DATA_REQ(dreq), .DATA_RDATA(rdata), .DATA_RBIT(rbit), .DATA_VALID(valid),
        .DATA_ERR(err));
    task automatic results();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One data request, held for exactly one taking edge.
    task automatic dop(logic w, data_mode_e m, logic [7:0] ad, logic [7:0] d, logic b);
        @(posedge clk);
        #1 dreq = '{!w, w, m, ad, d, b};
        @(posedge clk);
        #1 dreq = '0;
    endtask
    task automatic pop(logic w, logic [15:0] ad);
        @(posedge clk);
        #1 preq = '{!w, w, ad, ad[7:0]};
        @(posedge clk);
        #1 preq = '0;
    endtask
    // Program address for step k: size boundaries, the reserved edge, then random.
    function automatic logic [15:0] padr(int k, logic [7:0] r);
        if (k < 8) return {2'(k >> 1), 14'h3FFF} + 16'(k & 1);
        if (k < 12) return 16'hFBF7 + 16'(k);
        return {r, r};
    endfunction
    // Expected {flash_hit, reserved, unbacked} for one program address.
    function automatic logic [2:0] pexp(flash_size_e f, logic [15:0] ad);
        logic [16:0] top;
        top = f == FLASH_64K ? FLASH_END_64K : f == FLASH_32K ? FLASH_END_32K : FLASH_END_16K;
        if (f == FLASH_64K && ad > PROG_LAST_USABLE_64K) return 3'b010;
        return {1'b0, ad} < top ? 3'b100 : 3'b001;
    endfunction
    // Watchdog: the sequence needs a few thousand cycles at most.
    initial begin
        #200us;
        error_cnt++;
        results();
    end
    initial begin
        clk = 0;
        rstn = 0;
        {edm, psc, bank, preq, dreq} = '0;
        fsz = FLASH_64K;
        void'($urandom(72));
        repeat (5) @(posedge clk);
        #1 rstn = 1;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'($urandom);
            dop(1, MODE_INDIRECT, 8'(i), mem[i], 0);
        end
        for (int i = 0; i < 256; i++) begin
            dop(0, i < 128 ? MODE_DIRECT : MODE_INDIRECT, 8'(i), 8'h00, 0);
            check("rdata", rdata, mem[i]);
        end
        // Upper half refused for direct and bit forms, taken indirectly.
        for (int m = 0; m < 4; m++) begin
            dop(0, data_mode_e'(m), 8'h80 | 8'($urandom), 8'h00, 0);
            check("err", err, m == 0 || m == 3);
            check("valid", valid, m == 1 || m == 2);
        end
        for (int i = 0; i < 32; i++) begin
            bank = 2'(i >> 3);
            dop(0, MODE_REGISTER, {5'($urandom), 3'(i)}, 8'h00, 0);
            check("bank reg", rdata, mem[i]);
        end
        for (int i = 0; i < 16; i++) begin
            a = 8'($urandom) & 8'h7F;
            y = 8'h20 + 8'(a[6:3]);
            dop(0, MODE_BIT, a, 8'h00, 0);
            check("bit", rbit, mem[y][a[2:0]]);
            mem[y][a[2:0]] = ~mem[y][a[2:0]];
            dop(1, MODE_BIT, a, mem[y] ^ (8'h01 << a[2:0]), mem[y][a[2:0]]);
            dop(0, MODE_DIRECT, y, 8'h00, 0);
            check("bit byte", rdata, mem[y]);
        end
        for (int f = 0; f < 3; f++) begin
            fsz = flash_size_e'(f);
            for (int k = 0; k < 16; k++) begin
                a = 8'($urandom);
                pop(0, padr(k, a));
                check("flags", {pans.flash_hit, pans.reserved, pans.unbacked}, pexp(fsz, padr(k, a)));
            end
        end
        fsz = FLASH_64K;
        for (int c = 0; c < 16; c++) begin
            psc = {7'($urandom), c[0]};
            edm = c[1];
            pop(c[2], c[3] ? 16'hFC10 : 16'h1234);
            check("store", pans.store_wr, c == 7);
            check("store addr", pans.store_addr, c[3] ? 16'hFC10 : 16'h1234);
            check("store data", pans.store_data, c[3] ? 16'h0010 : 16'h0034);
        end
        results();
    end
endmodule
